// [uart_mode_control_status.sv]
// Function
// - Each frame starts with a start bit; transmit and receive run independently.
// - Two selectable pin pairs; only one input and one output active.
// - Mode bit 7 enables the transmitter; zero halts it.
// - Mode bit 6 enables the receiver; zero halts it.
// - Mode bits 5:4: none, forced zero unchecked, odd, even parity.
// - Mode bit 3 picks seven or eight data bits.
// - Mode bit 2 picks one or two transmitted stop bits.
// - Receiver checks only one stop bit regardless of setting.
// - Mode bit 1 set suppresses receive-complete pulse on errored frames.
// - Mode bit 0 picks external pin clock or internal generator.
// - Internal generator selected frees the external clock pin.
// - Status register is read-only, bits 7 to 3 read zero.
// - Status bit 2 flags received parity mismatch.
// - Status bit 1 flags missing stop bit.
// - Status bit 0 flags frame completed before buffer was read.
// - Overrun keeps flagging on each frame until buffer is read.
// - Reset clears mode register to zero.
// - Internal generator can reach 31.25 kbps.
// - Internal rate is system clock over 2^n times k plus 16.
// - External rate is pin frequency over 2 times k plus 16.
// - Pin-route field picks input and output pins independently.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module uart_mode_control_status
  import uart_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output var  logic [7:0]        rdata,
  input  wire logic              rxdPinA,
  input  wire logic              rxdPinB,
  input  wire logic              extBaudClkPin,
  output var  logic              txdPinA,
  output var  logic              txdPinB,
  output var  logic              txdOeA,
  output var  logic              txdOeB,
  output var  logic              extBaudPinFree,
  output var  logic              rxDoneIrq,
  output var  logic              txDoneIrq
);

  // ==========================================================
  // Registers and state
  logic [7:0] modeReg_r;
  logic [7:0] statusReg_r;
  logic [7:0] syncModeReg_r;
  logic [7:0] baudDivReg_r;
  logic [7:0] pinRouteReg_r;
  logic [7:0] rxBuf_r;
  logic       rxFull_r;
  logic       rxA1_r, rxA2_r, rxB1_r, rxB2_r, ext1_r, ext2_r;
  logic       rxLine_r, rxPrev_r;
  logic       srcTick, halfTick;
  txState_t   txState_r;
  logic [7:0] txShift_r;
  logic [2:0] txBitIdx_r;
  logic       txHalf_r, txStop2_r, txParBit_r, txLine_r;
  rxState_t   rxState_r;
  logic [7:0] rxShift_r;
  logic [2:0] rxBitIdx_r;
  logic [4:0] rxHalfCnt_r;
  logic       rxWait_r, rxParBit_r;

  logic       txEnable, rxEnable, charLen8, stopTwo, errMask, clkInternal;
  logic [1:0] parSel;
  logic [2:0] lastBit;
  logic       wrData, rdData, rdStatus;
  logic       rxHalfEvt, sampleNow, rxDoneEvt, peNow, feNow;

  always_comb begin
    txEnable    = modeReg_r[MODE_TXEN];
    rxEnable    = modeReg_r[MODE_RXEN];
    parSel      = modeReg_r[MODE_PAR_HI:MODE_PAR_LO];
    charLen8    = modeReg_r[MODE_CLEN];
    stopTwo     = modeReg_r[MODE_STOP];
    errMask     = modeReg_r[MODE_ERRMASK];
    clkInternal = modeReg_r[MODE_CLKSRC];
    lastBit     = charLen8 ? 3'h7 : 3'h6;
    wrData      = wrStb && addr == DATA_ADDR;
    rdData      = rdStb && addr == DATA_ADDR;
    rdStatus    = rdStb && addr == STATUS_ADDR;
  end

  // ==========================================================
  // Register writes; software keeps both paths halted while changing modes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      modeReg_r     <= MODE_RST;
      syncModeReg_r <= SYNC_RST;
      baudDivReg_r  <= BAUD_RST;
      pinRouteReg_r <= ROUTE_RST;
    end else if (ce && wrStb) begin
      if (addr == MODE_ADDR) begin
        modeReg_r <= wdata;
      end else if (addr == SYNC_ADDR) begin
        syncModeReg_r <= wdata & SYNC_WR_MASK;
      end else if (addr == BAUD_ADDR) begin
        baudDivReg_r <= wdata;
      end else if (addr == ROUTE_ADDR) begin
        pinRouteReg_r <= wdata & ROUTE_WR_MASK;
      end
    end
  end

  // ==========================================================
  // Register reads: data stands one cycle, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rdStb) begin
        if (addr == MODE_ADDR) begin
          rdata <= modeReg_r;
        end else if (addr == STATUS_ADDR) begin
          rdata <= {5'h00, statusReg_r[2:0]};
        end else if (addr == SYNC_ADDR) begin
          rdata <= syncModeReg_r;
        end else if (addr == BAUD_ADDR) begin
          rdata <= baudDivReg_r;
        end else if (addr == ROUTE_ADDR) begin
          rdata <= pinRouteReg_r;
        end else if (addr == DATA_ADDR) begin
          rdata <= rxBuf_r;
        end else if (addr == LINE_ADDR) begin
          rdata <= {6'h00, txState_r != TX_IDLE, rxFull_r};
        end
      end
    end
  end

  // ==========================================================
  // Pin synchronisers and input pin routing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxA1_r   <= 1'b1;
      rxA2_r   <= 1'b1;
      rxB1_r   <= 1'b1;
      rxB2_r   <= 1'b1;
      ext1_r   <= 1'b0;
      ext2_r   <= 1'b0;
      rxLine_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else if (ce) begin
      rxA1_r   <= rxdPinA;
      rxA2_r   <= rxA1_r;
      rxB1_r   <= rxdPinB;
      rxB2_r   <= rxB1_r;
      ext1_r   <= extBaudClkPin;
      ext2_r   <= ext1_r;
      rxLine_r <= pinRouteReg_r[ROUTE_IN] ? rxB2_r : rxA2_r;
      rxPrev_r <= rxLine_r;
    end
  end

  uart_baud_gen u_baud (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .ce          (ce),
    .extClkSync  (ext2_r),
    .useInternal (clkInternal),
    .tpsCode     (baudDivReg_r[BAUD_TPS_LSB +: 4]),
    .divK        (baudDivReg_r[BAUD_K_LSB +: 4]),
    .srcTick     (srcTick),
    .halfTick    (halfTick)
  );

  // ==========================================================
  // Transmitter: a bit lasts two half ticks; waits for a tick first
  // so the start bit is never shortened
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txState_r  <= TX_IDLE;
      txShift_r  <= 8'h00;
      txBitIdx_r <= 3'h0;
      txHalf_r   <= 1'b0;
      txStop2_r  <= 1'b0;
      txParBit_r <= 1'b0;
      txLine_r   <= 1'b1;
      txDoneIrq  <= 1'b0;
    end else if (ce) begin
      txDoneIrq <= 1'b0;
      if (!txEnable) begin
        txState_r <= TX_IDLE;
        txLine_r  <= 1'b1;
      end else begin
        case (txState_r)
          TX_IDLE: begin
            txLine_r <= 1'b1;
            if (wrData) begin
              txShift_r  <= charLen8 ? wdata : {1'b0, wdata[6:0]};
              txParBit_r <= parityOf(wdata, charLen8, parSel);
              txState_r  <= TX_ARMED;
            end
          end
          TX_ARMED: begin
            if (halfTick) begin
              txLine_r   <= 1'b0;
              txHalf_r   <= 1'b0;
              txBitIdx_r <= 3'h0;
              txState_r  <= TX_START;
            end
          end
          default: begin
            if (halfTick) begin
              txHalf_r <= !txHalf_r;
              if (txHalf_r) begin
                case (txState_r)
                  TX_START: begin
                    txLine_r  <= txShift_r[0];
                    txState_r <= TX_DATA;
                  end
                  TX_DATA: begin
                    if (txBitIdx_r == lastBit) begin
                      txLine_r  <= (parSel == PAR_NONE) ? 1'b1 : txParBit_r;
                      txState_r <= (parSel == PAR_NONE) ? TX_STOP : TX_PARITY;
                      txStop2_r <= stopTwo;
                    end else begin
                      txBitIdx_r <= txBitIdx_r + 3'h1;
                      txLine_r   <= txShift_r[txBitIdx_r + 3'h1];
                    end
                  end
                  TX_PARITY: begin
                    txLine_r  <= 1'b1;
                    txState_r <= TX_STOP;
                  end
                  default: begin
                    if (txStop2_r) begin
                      txStop2_r <= 1'b0;
                    end else begin
                      txState_r <= TX_IDLE;
                      txDoneIrq <= 1'b1;
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  // Only the routed output pin is driven, and only while enabled
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txdPinA        <= 1'b1;
      txdPinB        <= 1'b1;
      txdOeA         <= 1'b0;
      txdOeB         <= 1'b0;
      extBaudPinFree <= 1'b0;
    end else if (ce) begin
      txdPinA        <= pinRouteReg_r[ROUTE_OUT] ? 1'b1 : txLine_r;
      txdPinB        <= pinRouteReg_r[ROUTE_OUT] ? txLine_r : 1'b1;
      txdOeA         <= txEnable && !pinRouteReg_r[ROUTE_OUT];
      txdOeB         <= txEnable && pinRouteReg_r[ROUTE_OUT];
      extBaudPinFree <= clkInternal;
    end
  end

  // ==========================================================
  // Receiver: own half-bit counter restarts on the start edge,
  // so sampling lands mid-bit whatever the transmit phase
  always_comb begin
    rxHalfEvt = srcTick && (rxHalfCnt_r >= 5'(baudDivReg_r[BAUD_K_LSB +: 4]) + HALF_BASE);
    sampleNow = rxHalfEvt && !rxWait_r && rxState_r != RX_IDLE;
    rxDoneEvt = sampleNow && rxState_r == RX_STOP && rxEnable;
    feNow     = !rxLine_r;
    peNow     = (parSel == PAR_ODD || parSel == PAR_EVEN) &&
                (rxParBit_r != parityOf(rxShift_r, charLen8, parSel));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxState_r   <= RX_IDLE;
      rxShift_r   <= 8'h00;
      rxBitIdx_r  <= 3'h0;
      rxHalfCnt_r <= 5'h00;
      rxWait_r    <= 1'b0;
      rxParBit_r  <= 1'b0;
    end else if (ce) begin
      if (srcTick) begin
        rxHalfCnt_r <= rxHalfEvt ? 5'h00 : rxHalfCnt_r + 5'h01;
      end
      if (rxHalfEvt) begin
        rxWait_r <= !rxWait_r;
      end
      if (!rxEnable) begin
        rxState_r <= RX_IDLE;
      end else if (rxState_r == RX_IDLE) begin
        if (rxPrev_r && !rxLine_r) begin
          rxState_r   <= RX_START;
          rxHalfCnt_r <= 5'h00;
          rxWait_r    <= 1'b0;
          rxShift_r   <= 8'h00;
          rxBitIdx_r  <= 3'h0;
        end
      end else if (sampleNow) begin
        case (rxState_r)
          RX_START: begin
            rxState_r <= rxLine_r ? RX_IDLE : RX_DATA;
          end
          RX_DATA: begin
            rxShift_r[rxBitIdx_r] <= rxLine_r;
            rxBitIdx_r <= rxBitIdx_r + 3'h1;
            if (rxBitIdx_r == lastBit) begin
              rxState_r <= (parSel == PAR_NONE) ? RX_STOP : RX_PARITY;
            end
          end
          RX_PARITY: begin
            rxParBit_r <= rxLine_r;
            rxState_r  <= RX_STOP;
          end
          default: begin
            rxState_r <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Completion: buffer, status and receive-complete pulse.
  // A frame completing in the cycle of a buffer read keeps it full.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxBuf_r     <= 8'h00;
      rxFull_r    <= 1'b0;
      statusReg_r <= STATUS_RST;
      rxDoneIrq   <= 1'b0;
    end else if (ce) begin
      rxDoneIrq <= 1'b0;
      if (rxDoneEvt) begin
        rxBuf_r                   <= rxShift_r;
        rxFull_r                  <= 1'b1;
        statusReg_r[STAT_PARITY]  <= peNow;
        statusReg_r[STAT_FRAMING] <= feNow;
        statusReg_r[STAT_LOST]    <= rxFull_r;
        rxDoneIrq <= !(errMask && (peNow || feNow || rxFull_r));
      end else if (rdData) begin
        rxFull_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_frameDone;
    ce && rxDoneEvt;
  endsequence

  property p_modeReset;
    $fell(rst) |-> modeReg_r == MODE_RST;
  endproperty
  a_modeReset: assert property (p_modeReset) else $error("mode not cleared by reset");

  property p_txHalted;
    ce && !txEnable |=> txState_r == TX_IDLE && txLine_r;
  endproperty
  a_txHalted: assert property (p_txHalted) else $error("transmitter ran while halted");

  property p_rxHalted;
    ce && !rxEnable |=> rxState_r == RX_IDLE && !rxDoneIrq;
  endproperty
  a_rxHalted: assert property (p_rxHalted) else $error("receiver ran while halted");

  property p_onePin;
    !(txdOeA && txdOeB);
  endproperty
  a_onePin: assert property (p_onePin) else $error("both output pins driven");

  property p_statusZeros;
    ce && rdStatus |=> rdata[7:3] == 5'h00;
  endproperty
  a_statusZeros: assert property (p_statusZeros) else $error("status high bits not zero");

  property p_overrun;
    s_frameDone and rxFull_r |=> statusReg_r[STAT_LOST] && rxFull_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_framing;
    s_frameDone and !rxLine_r |=> statusReg_r[STAT_FRAMING];
  endproperty
  a_framing: assert property (p_framing) else $error("missing stop bit not flagged");

  property p_zeroParity;
    s_frameDone and parSel == PAR_ZERO |=> !statusReg_r[STAT_PARITY];
  endproperty
  a_zeroParity: assert property (p_zeroParity) else $error("parity checked in zero mode");

  property p_errMask;
    s_frameDone and errMask |=> rxDoneIrq == (statusReg_r[STAT_PARITY:STAT_LOST] == 3'h0);
  endproperty
  a_errMask: assert property (p_errMask) else $error("pulse on errored frame");

  property p_idleHigh;
    ce && txState_r == TX_IDLE |=> txLine_r;
  endproperty
  a_idleHigh: assert property (p_idleHigh) else $error("line not idling high");

endmodule
`default_nettype wire

// [uart_pkg.sv]
`default_nettype none
package uart_pkg;

  // ==========================================================
  // Register map
  localparam int          ADDR_W        = 16;
  localparam logic [15:0] MODE_ADDR     = 16'hFF70;
  localparam logic [15:0] STATUS_ADDR   = 16'hFF71;
  localparam logic [15:0] SYNC_ADDR     = 16'hFF72;
  localparam logic [15:0] BAUD_ADDR     = 16'hFF73;
  localparam logic [15:0] ROUTE_ADDR    = 16'hFF75;
  localparam logic [15:0] DATA_ADDR     = 16'hFF76;
  localparam logic [15:0] LINE_ADDR     = 16'hFF77;

  // ==========================================================
  // Reset values and writable masks
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam logic [7:0]  SYNC_RST      = 8'h00;
  localparam logic [7:0]  BAUD_RST      = 8'h00;
  localparam logic [7:0]  ROUTE_RST     = 8'h00;
  localparam logic [7:0]  SYNC_WR_MASK  = 8'h86;
  localparam logic [7:0]  ROUTE_WR_MASK = 8'h30;

  // ==========================================================
  // Field positions
  localparam int MODE_TXEN    = 7;
  localparam int MODE_RXEN    = 6;
  localparam int MODE_PAR_HI  = 5;
  localparam int MODE_PAR_LO  = 4;
  localparam int MODE_CLEN    = 3;
  localparam int MODE_STOP    = 2;
  localparam int MODE_ERRMASK = 1;
  localparam int MODE_CLKSRC  = 0;
  localparam int STAT_PARITY  = 2;
  localparam int STAT_FRAMING = 1;
  localparam int STAT_LOST    = 0;
  localparam int ROUTE_IN     = 4;
  localparam int ROUTE_OUT    = 5;
  localparam int BAUD_TPS_LSB = 4;
  localparam int BAUD_K_LSB   = 0;

  // ==========================================================
  // Parity selector encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // ==========================================================
  // Baud divider: fixed 16 plus k source ticks per half bit
  localparam logic [4:0] HALF_BASE   = 5'h0F;
  localparam logic [3:0] TPS_N_MAX   = 4'hB;
  localparam logic [3:0] TPS_N_OFFS  = 4'h4;
  localparam logic [3:0] TPS_LO_CODE = 4'h5;
  localparam logic [3:0] TPS_HI_CODE = 4'hE;
  localparam int         PRESC_W     = 11;

  typedef enum logic [2:0] {TX_IDLE, TX_ARMED, TX_START, TX_DATA, TX_PARITY,
                            TX_STOP} txState_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY,
                            RX_STOP} rxState_t;

  // Parity bit that goes with a character under the given selector
  function automatic logic parityOf(input logic [7:0] d, input logic len8,
                                    input logic [1:0] sel);
    logic ones;
    ones = ^(len8 ? d : {1'b0, d[6:0]});
    case (sel)
      PAR_ODD:  parityOf = ~ones;
      PAR_EVEN: parityOf = ones;
      default:  parityOf = 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

// [uart_baud_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen
  import uart_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       extClkSync,
  input  wire logic       useInternal,
  input  wire logic [3:0] tpsCode,
  input  wire logic [3:0] divK,
  output var  logic       srcTick,
  output var  logic       halfTick
);

  logic [PRESC_W-1:0] prescCnt_r;
  logic               extPrev_r;
  logic [4:0]         divCnt_r;
  logic [3:0]         nVal;
  logic [PRESC_W-1:0] prescLast;
  logic               srcNow;

  // ==========================================================
  // Source clock: system clock over 2^(n-1), or external edges
  always_comb begin
    if (tpsCode >= TPS_LO_CODE && tpsCode <= TPS_HI_CODE) begin
      nVal = tpsCode - TPS_N_OFFS;
    end else begin
      nVal = TPS_N_MAX;
    end
    prescLast = PRESC_W'((12'h001 << (nVal - 4'h1)) - 12'h001);
    srcNow    = useInternal ? (prescCnt_r == prescLast) : (extClkSync && !extPrev_r);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescCnt_r <= '0;
      extPrev_r  <= 1'b0;
    end else if (ce) begin
      extPrev_r  <= extClkSync;
      prescCnt_r <= (!useInternal || prescCnt_r >= prescLast) ? '0 : prescCnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Half-bit tick every 16+k source ticks; two make one bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt_r <= '0;
      srcTick  <= 1'b0;
      halfTick <= 1'b0;
    end else if (ce) begin
      srcTick  <= srcNow;
      halfTick <= 1'b0;
      if (srcNow) begin
        if (divCnt_r >= 5'(divK) + HALF_BASE) begin
          divCnt_r <= '0;
          halfTick <= 1'b1;
        end else begin
          divCnt_r <= divCnt_r + 5'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [uart_remote_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Remote serial device on the data pins
module uart_remote_model
  import uart_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic txWire,
  output var  logic lineOut
);
  initial lineOut = 1'b1;

  // ==========
  // Parity rule of the far side
  function automatic logic parBit(input logic [7:0] d, input logic len8,
                                  input logic [1:0] par);
    parBit = (par == PAR_ZERO) ? 1'b0 : (^(len8 ? d : {1'b0, d[6:0]}) ^ (par == PAR_ODD));
  endfunction

  // ==========
  // Frame out, single stop; knobs corrupt parity or stop
  task automatic sendFrame(input logic [7:0] d, input logic len8, input logic [1:0] par,
                           input logic badPar, input logic badStop, input int bitc);
    logic [11:0] bits;
    int          n;
    bits = {3'b111, d, 1'b0};
    n = len8 ? 9 : 8;
    if (par != PAR_NONE) begin
      bits[n] = parBit(d, len8, par) ^ badPar;
      n++;
    end
    bits[n] = ~badStop;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys);
      lineOut <= bits[i];
      repeat (bitc - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    lineOut <= 1'b1;
  endtask

  // ==========
  // Frame in, sampled mid-bit on the falling clock edge to avoid races
  task automatic recvFrame(input int bitc, output logic [11:0] bits);
    int w;
    w = 0;
    while (txWire !== 1'b0 && w < 20000) begin
      @(negedge clk_sys);
      w++;
    end
    repeat (bitc / 2) @(negedge clk_sys);
    for (int i = 0; i < 12; i++) begin
      bits[i] = txWire;
      repeat (bitc) @(negedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// [uart_mode_control_status_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_mode_control_status_tb_top
  import uart_pkg::*;
;
  // ==========
  // Pins and bookkeeping
  logic              clk_sys, lineOut, txdPinA, txdPinB, txdOeA, txdOeB;
  logic              extBaudPinFree, rxDoneIrq, txDoneIrq;
  logic              rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rtB = 1'b0, extBaudClkPin = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = 8'h00, rdata;
  logic [2:0]        extDiv = 3'h0;
  logic [3:0]        cfgs [4] = '{4'b0010, 4'b0101, 4'b1010, 4'b1101};
  int                cyc = 0, rxSeen = 0, txSeen = 0, txDoneCyc = 0, errTotal = 0, nChecks = 0;
  wire logic         txWire;
  // Unselected output reads as a pulled-up idle line
  assign txWire = (txdOeA ? txdPinA : 1'b1) & (txdOeB ? txdPinB : 1'b1);

  uart_mode_control_status i_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .rxdPinA(rtB ? 1'b1 : lineOut),
    .rxdPinB(rtB ? lineOut : 1'b1), .extBaudClkPin(extBaudClkPin), .txdPinA(txdPinA),
    .txdPinB(txdPinB), .txdOeA(txdOeA), .txdOeB(txdOeB), .extBaudPinFree(extBaudPinFree),
    .rxDoneIrq(rxDoneIrq), .txDoneIrq(txDoneIrq)
  );
  uart_remote_model i_remote (.clk_sys(clk_sys), .txWire(txWire), .lineOut(lineOut));

  // ==========
  // Clocks and pulse counters
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // External baud pin runs free at an eighth of the system clock
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    extDiv <= extDiv + 3'h1;
    extBaudClkPin <= extDiv[2];
    if (rxDoneIrq === 1'b1) rxSeen <= rxSeen + 1;
    if (txDoneIrq === 1'b1) begin
      txSeen <= txSeen + 1;
      txDoneCyc <= cyc;
    end
  end

  // ==========
  // Register bus and frame tasks
  task automatic wrReg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk_sys);
    wrStb <= 1'b0;
  endtask
  task automatic chkReg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic setMode(input logic [7:0] m);
    wrReg(MODE_ADDR, 8'h00);
    wrReg(MODE_ADDR, m);
  endtask
  task automatic txCheck(input logic [7:0] d, input logic len8, input logic [1:0] par,
                         input logic stop2, input int bitc);
    logic [11:0] fr, ex, mk;
    int          nb, t0;
    ex = {3'b111, d, 1'b0};
    nb = len8 ? 9 : 8;
    if (par != PAR_NONE) begin
      ex[nb] = i_remote.parBit(d, len8, par);
      nb++;
    end
    ex[nb] = 1'b1;
    nb++;
    mk = (12'h001 << nb) - 12'h001;
    t0 = cyc;
    fork
      wrReg(DATA_ADDR, d);
      i_remote.recvFrame(bitc, fr);
    join
    `CHK(fr & mk, ex & mk)
    `CHK((txDoneCyc - t0) / bitc, nb + stop2)
  endtask
  task automatic rxCheck(input logic [7:0] d, input logic len8, input logic [1:0] par,
                         input logic [1:0] bad, input logic [7:0] st, input int irq,
                         input logic rd, input int bitc);
    int s;
    s = rxSeen;
    i_remote.sendFrame(d, len8, par, bad[1], bad[0], bitc);
    repeat (8) @(posedge clk_sys);
    `CHK(rxSeen - s, irq)
    chkReg(STATUS_ADDR, st);
    if (rd) chkReg(DATA_ADDR, len8 ? d : {1'b0, d[6:0]});
  endtask
  task automatic closeOut;
    if (errTotal == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    int s0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    chkReg(MODE_ADDR, 8'h00);
    chkReg(STATUS_ADDR, 8'h00);
    chkReg(SYNC_ADDR, 8'h00);
    `CHK({txdOeA, txdOeB, extBaudPinFree, txWire}, 4'b0001)
    wrReg(SYNC_ADDR, 8'h00);
    wrReg(STATUS_ADDR, 8'hFF);
    chkReg(STATUS_ADDR, 8'h00);
    chkReg(16'hFF74, 8'h00);
    wrReg(BAUD_ADDR, 8'h50);
    for (int i = 0; i < 4; i++) begin
      setMode({2'b11, cfgs[i], 2'b01});
      txCheck(8'hB5 ^ i[7:0], cfgs[i][1], cfgs[i][3:2], cfgs[i][0], 32);
      `CHK(extBaudPinFree, 1'b1)
      rxCheck(8'h4B ^ i[7:0], cfgs[i][1], cfgs[i][3:2], 2'b00, 8'h00, 1, 1'b1, 32);
    end
    setMode(8'hFD);
    rxCheck(8'h5A, 1'b1, PAR_EVEN, 2'b10, 8'h04, 1, 1'b1, 32);
    rxCheck(8'h66, 1'b1, PAR_EVEN, 2'b01, 8'h02, 1, 1'b1, 32);
    // Back to back with one stop while two are selected
    i_remote.sendFrame(8'h11, 1'b1, PAR_EVEN, 1'b0, 1'b0, 32);
    rxCheck(8'h22, 1'b1, PAR_EVEN, 2'b00, 8'h01, 1, 1'b0, 32);
    rxCheck(8'h33, 1'b1, PAR_EVEN, 2'b00, 8'h01, 1, 1'b1, 32);
    rxCheck(8'h44, 1'b1, PAR_EVEN, 2'b00, 8'h00, 1, 1'b1, 32);
    setMode(8'hFF);
    rxCheck(8'h77, 1'b1, PAR_EVEN, 2'b10, 8'h04, 0, 1'b1, 32);
    rxCheck(8'h78, 1'b1, PAR_EVEN, 2'b00, 8'h00, 1, 1'b1, 32);
    setMode(8'hD9);
    rxCheck(8'h99, 1'b1, PAR_ZERO, 2'b10, 8'h00, 1, 1'b1, 32);
    setMode(8'h89);
    rxCheck(8'h55, 1'b1, PAR_NONE, 2'b00, 8'h00, 0, 1'b0, 32);
    setMode(8'h49);
    s0 = txSeen;
    wrReg(DATA_ADDR, 8'hAA);
    repeat (400) @(posedge clk_sys);
    `CHK(txSeen - s0, 0)
    `CHK({txdOeA, txWire}, 2'b01)
    wrReg(MODE_ADDR, 8'h00);
    wrReg(ROUTE_ADDR, 8'h30);
    chkReg(ROUTE_ADDR, 8'h30);
    @(posedge clk_sys) rtB <= 1'b1;
    setMode(8'hC9);
    repeat (2) @(negedge clk_sys);
    `CHK({txdOeA, txdOeB}, 2'b01)
    txCheck(8'h3C, 1'b1, PAR_NONE, 1'b0, 32);
    rxCheck(8'hC3, 1'b1, PAR_NONE, 2'b00, 8'h00, 1, 1'b1, 32);
    setMode(8'hC8);
    txCheck(8'hE1, 1'b1, PAR_NONE, 1'b0, 256);
    `CHK(extBaudPinFree, 1'b0)
    rxCheck(8'h1E, 1'b1, PAR_NONE, 2'b00, 8'h00, 1, 1'b1, 256);
    chkReg(BAUD_ADDR, 8'h50);
    wrReg(MODE_ADDR, 8'h00);
    wrReg(BAUD_ADDR, 8'h99);
    setMode(8'hC9);
    txCheck(8'h5C, 1'b1, PAR_NONE, 1'b0, 800);
    closeOut;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    errTotal++;
    closeOut;
  end
endmodule
`default_nettype wire
